// File: core/oobh_regs.vh
`ifndef OOBH_REGS_VH
`define OOBH_REGS_VH

// Core clock rate in kHz
`define OOBH_CLK_KHZ          10000
// Timer periods in their own units
`define OOBH_HOTPLUG_MS       100
`define OOBH_HOTPLUG_MIN_MS   10
`define OOBH_HOTPLUG_MAX_MS   500
`define OOBH_IDDET_NS         3500
`define OOBH_SNW_NS           109220
`define OOBH_ALIGN_US         880
`define OOBH_SYNC_LOSS_US     100
// Derived cycle counts (least times round up, longest round down)
`define OOBH_HOTPLUG_CYC      (`OOBH_HOTPLUG_MS * `OOBH_CLK_KHZ)
`define OOBH_IDDET_CYC        ((`OOBH_IDDET_NS * (`OOBH_CLK_KHZ / 1000)) / 1000)
`define OOBH_SNW_CYC          ((`OOBH_SNW_NS * (`OOBH_CLK_KHZ / 1000) + 999) / 1000)
`define OOBH_ALIGN_CYC        (`OOBH_ALIGN_US * (`OOBH_CLK_KHZ / 1000))
`define OOBH_SYNC_LOSS_CYC    (`OOBH_SYNC_LOSS_US * (`OOBH_CLK_KHZ / 1000))

`define OOBH_TMR_W            24
`define OOBH_ST_W             11

`endif

// File: core/oobh_handshake.v
`timescale 1ns/1ps
`include "oobh_regs.vh"

module oobh_handshake #(
    parameter [`OOBH_TMR_W-1:0] HOTPLUG_CYC = `OOBH_HOTPLUG_CYC,
    parameter [`OOBH_TMR_W-1:0] IDDET_CYC   = `OOBH_IDDET_CYC,
    parameter [`OOBH_TMR_W-1:0] SNW_CYC     = `OOBH_SNW_CYC,
    parameter [`OOBH_TMR_W-1:0] ALIGN_CYC   = `OOBH_ALIGN_CYC,
    parameter [`OOBH_TMR_W-1:0] SYNC_CYC    = `OOBH_SYNC_LOSS_CYC,
    parameter                   LEGACY_SUPPORT = 1'b1
) (
    input  wire SYS_CLK,
    input  wire RST,
    input  wire POWER_ON_RESET_IN,
    input  wire UPPER_LAYER_RESET,
    input  wire INIT_DETECT_STROBE,
    input  wire ID_DETECT_STROBE,
    input  wire ID_END_DETECT,
    input  wire INIT_SENT_STROBE,
    input  wire ID_SENT_STROBE,
    input  wire NEGOTIATE_FAIL,
    input  wire NEGOTIATE_DONE,
    input  wire LEGACY_ALIGN_SEEN,
    input  wire LEGACY_READY,
    input  wire SYNC_LOST,
    output reg  SEND_INIT_BURST,
    output reg  SEND_ID_BURST,
    output reg  NEGOTIATE_START,
    output reg  LEGACY_START,
    output reg  LINK_READY_OUT,
    output reg  FALLBACK_FLAG,
    output reg  SUCCESS_FLAG,
    output reg  SYNC_MON_ENABLE,
    output reg  [`OOBH_ST_W-1:0] STATE
);

////////////////////////////////////////////////////////////////////////////////
// One-hot states; negotiation and emulation are entry points only

localparam [`OOBH_ST_W-1:0] ST_RESET          = 11'h001;
localparam [`OOBH_ST_W-1:0] ST_AWAIT_OOB      = 11'h002;
localparam [`OOBH_ST_W-1:0] ST_SEND_ID_BURST  = 11'h004;
localparam [`OOBH_ST_W-1:0] ST_WAIT_ID_END    = 11'h008;
localparam [`OOBH_ST_W-1:0] ST_AWAIT_ID_BURST = 11'h010;
localparam [`OOBH_ST_W-1:0] ST_NEGOTIATE      = 11'h020;
localparam [`OOBH_ST_W-1:0] ST_NEG_FAIL_WAIT  = 11'h040;
localparam [`OOBH_ST_W-1:0] ST_LINK_READY     = 11'h080;
localparam [`OOBH_ST_W-1:0] ST_LEGACY_ALIGN   = 11'h100;
localparam [`OOBH_ST_W-1:0] ST_LEGACY_READY   = 11'h200;
localparam [`OOBH_ST_W-1:0] ST_SPARE          = 11'h400;

localparam [`OOBH_TMR_W-1:0] TMR_ZERO = 24'h000000;
localparam [`OOBH_TMR_W-1:0] TMR_ONE  = 24'h000001;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: all link-side inputs come from the analog front end

// Lane positions in the synchroniser word
localparam NSYNC     = 12;
localparam L_POR     = 11;
localparam L_UPPER   = 10;
localparam L_INITDET = 9;
localparam L_IDDET   = 8;
localparam L_IDEND   = 7;
localparam L_INITSNT = 6;
localparam L_IDSNT   = 5;
localparam L_NEGFAIL = 4;
localparam L_NEGDONE = 3;
localparam L_ALIGN   = 2;
localparam L_LEGRDY  = 1;
localparam L_SYNCLST = 0;

reg  [NSYNC-1:0] sync1_ff;
reg  [NSYNC-1:0] sync2_ff;
wire [NSYNC-1:0] raw_in;

assign raw_in = {POWER_ON_RESET_IN, UPPER_LAYER_RESET, INIT_DETECT_STROBE,
                 ID_DETECT_STROBE, ID_END_DETECT, INIT_SENT_STROBE,
                 ID_SENT_STROBE, NEGOTIATE_FAIL, NEGOTIATE_DONE,
                 LEGACY_ALIGN_SEEN, LEGACY_READY, SYNC_LOST};

always @(posedge SYS_CLK) begin
    if (RST) begin
        sync1_ff <= {NSYNC{1'b0}};
        sync2_ff <= {NSYNC{1'b0}};
    end else begin
        sync1_ff <= raw_in;
        sync2_ff <= sync1_ff;
    end
end

wire por_s        = sync2_ff[L_POR];
wire upper_rst_s  = sync2_ff[L_UPPER];
wire init_det_s   = sync2_ff[L_INITDET];
wire id_det_s     = sync2_ff[L_IDDET];
wire id_end_s     = sync2_ff[L_IDEND];
wire init_sent_s  = sync2_ff[L_INITSNT];
wire id_sent_s    = sync2_ff[L_IDSNT];
wire neg_fail_s   = sync2_ff[L_NEGFAIL];
wire neg_done_s   = sync2_ff[L_NEGDONE];
wire align_s      = sync2_ff[L_ALIGN];
wire leg_ready_s  = sync2_ff[L_LEGRDY];
wire sync_lost_s  = sync2_ff[L_SYNCLST];

////////////////////////////////////////////////////////////////////////////////
// Handshake state machine

reg  [`OOBH_ST_W-1:0]  state_ff;
reg  [`OOBH_ST_W-1:0]  nxt_state;
reg  [`OOBH_ST_W-1:0]  prev_state_ff;
reg                    init_rx_ff;
reg                    nxt_init_rx;
reg                    id_rx_ff;
reg                    nxt_id_rx;
reg  [`OOBH_TMR_W-1:0] hotplug_ff;
reg  [`OOBH_TMR_W-1:0] iddet_ff;
reg  [`OOBH_TMR_W-1:0] snw_ff;
reg  [`OOBH_TMR_W-1:0] align_ff;
reg  [`OOBH_TMR_W-1:0] sync_ff;

wire entered     = (state_ff != prev_state_ff);
wire hotplug_exp = (hotplug_ff == TMR_ONE);
wire iddet_exp   = (iddet_ff == TMR_ONE);
wire align_exp   = (align_ff == TMR_ONE);
wire sync_exp    = (sync_ff == TMR_ONE);
// Sync loss only counts once the link is up
wire sync_watch  = sync_lost_s & SYNC_MON_ENABLE;

always @* begin
    nxt_state   = state_ff;
    nxt_init_rx = init_rx_ff;
    nxt_id_rx   = id_rx_ff;
    case (state_ff)
        ST_RESET: begin
            // Remember a reset burst seen while ours is going out
            if (init_det_s)
                nxt_init_rx = 1'b1;
            if (id_det_s)
                nxt_state = ST_SEND_ID_BURST;
            else if (!por_s && init_sent_s) begin
                if (init_rx_ff || init_det_s)
                    nxt_state = ST_SEND_ID_BURST;
                else
                    nxt_state = ST_AWAIT_OOB;
            end
        end
        ST_AWAIT_OOB: begin
            if (init_det_s || id_det_s)
                nxt_state = ST_SEND_ID_BURST;
            else if (hotplug_exp && !entered)
                nxt_state = ST_RESET;
        end
        ST_SEND_ID_BURST: begin
            if (id_det_s)
                nxt_id_rx = 1'b1;
            if (id_sent_s) begin
                if (id_rx_ff || id_det_s)
                    nxt_state = ST_WAIT_ID_END;
                else
                    nxt_state = ST_AWAIT_ID_BURST;
            end
        end
        ST_WAIT_ID_END: begin
            if (id_end_s)
                nxt_state = ST_NEGOTIATE;
        end
        ST_AWAIT_ID_BURST: begin
            // A legacy target may answer our identify burst with a reset burst
            if (id_det_s)
                nxt_state = ST_WAIT_ID_END;
            else if (init_det_s && LEGACY_SUPPORT)
                nxt_state = ST_LEGACY_ALIGN;
            else if (iddet_exp && !entered) begin
                if (LEGACY_SUPPORT)
                    nxt_state = ST_LEGACY_ALIGN;
                else
                    nxt_state = ST_AWAIT_OOB;
            end
        end
        ST_NEGOTIATE: begin
            // Negotiation runs outside; only its verdict is seen here
            if (neg_fail_s)
                nxt_state = ST_NEG_FAIL_WAIT;
            else if (neg_done_s)
                nxt_state = ST_LINK_READY;
        end
        ST_NEG_FAIL_WAIT: begin
            // Full hot-plug wait, then restart from reset bursts
            if (hotplug_exp && !entered)
                nxt_state = ST_RESET;
        end
        ST_LINK_READY: begin
            if (init_det_s)
                nxt_state = ST_RESET;
        end
        ST_LEGACY_ALIGN: begin
            // Emulation itself is outside; only the align watchdog lives here
            if (align_s)
                nxt_state = ST_LEGACY_READY;
            else if (align_exp && !entered)
                nxt_state = ST_RESET;
        end
        ST_LEGACY_READY: begin
            if (init_det_s)
                nxt_state = ST_RESET;
        end
        default: begin
            nxt_state = ST_RESET;
        end
    endcase
    if (sync_watch && sync_exp)
        nxt_state = ST_RESET;
    if (por_s || upper_rst_s)
        nxt_state = ST_RESET;
    // Forced resets come first so entry to reset from any other state drops all burst memory
    if (state_ff != ST_RESET && nxt_state == ST_RESET)
        nxt_init_rx = 1'b0;
    if (nxt_state != ST_SEND_ID_BURST)
        nxt_id_rx = 1'b0;
end

always @(posedge SYS_CLK) begin
    if (RST) begin
        state_ff      <= ST_RESET;
        prev_state_ff <= ST_SPARE;
        init_rx_ff    <= 1'b0;
        id_rx_ff      <= 1'b0;
    end else begin
        state_ff      <= nxt_state;
        prev_state_ff <= state_ff;
        init_rx_ff    <= (nxt_state == ST_RESET && state_ff != ST_RESET) ? 1'b0
                                                                        : nxt_init_rx;
        id_rx_ff      <= nxt_id_rx;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Timers: independent countdowns reloaded on state entry, except sync-loss, which reloads while no loss is watched
// A value of one marks expiry; zero means idle.

always @(posedge SYS_CLK) begin
    if (RST) begin
        hotplug_ff <= TMR_ZERO;
        iddet_ff   <= TMR_ZERO;
        snw_ff     <= TMR_ZERO;
        align_ff   <= TMR_ZERO;
        sync_ff    <= TMR_ZERO;
    end else begin
        // Shared by await and failure-wait states, which never overlap
        if (entered && (state_ff == ST_AWAIT_OOB || state_ff == ST_NEG_FAIL_WAIT))
            hotplug_ff <= HOTPLUG_CYC;
        else if (hotplug_ff > TMR_ONE)
            hotplug_ff <= hotplug_ff - TMR_ONE;
        if (entered && state_ff == ST_AWAIT_ID_BURST)
            iddet_ff <= IDDET_CYC;
        else if (iddet_ff > TMR_ONE)
            iddet_ff <= iddet_ff - TMR_ONE;
        // Window timer reloads each period while negotiating; no output carries it
        if (entered && state_ff == ST_NEGOTIATE)
            snw_ff <= SNW_CYC;
        else if (snw_ff == TMR_ONE)
            snw_ff <= (state_ff == ST_NEGOTIATE) ? SNW_CYC : TMR_ZERO;
        else if (snw_ff > TMR_ONE)
            snw_ff <= snw_ff - TMR_ONE;
        if (entered && state_ff == ST_LEGACY_ALIGN)
            align_ff <= ALIGN_CYC;
        else if (align_ff > TMR_ONE)
            align_ff <= align_ff - TMR_ONE;
        // Sync-loss counter runs only while loss persists
        if (!sync_watch)
            sync_ff <= SYNC_CYC;
        else if (sync_ff > TMR_ONE)
            sync_ff <= sync_ff - TMR_ONE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs

always @(posedge SYS_CLK) begin
    if (RST) begin
        SEND_INIT_BURST <= 1'b1;
        SEND_ID_BURST   <= 1'b0;
        NEGOTIATE_START <= 1'b0;
        LEGACY_START    <= 1'b0;
        LINK_READY_OUT  <= 1'b0;
        FALLBACK_FLAG   <= 1'b0;
        SUCCESS_FLAG    <= 1'b0;
        SYNC_MON_ENABLE <= 1'b0;
        STATE           <= ST_RESET;
    end else begin
        // Generator repeats six-burst groups while this level holds
        SEND_INIT_BURST <= (nxt_state == ST_RESET);
        SEND_ID_BURST   <= (nxt_state == ST_SEND_ID_BURST);
        NEGOTIATE_START <= (nxt_state == ST_NEGOTIATE) && (state_ff != ST_NEGOTIATE);
        LEGACY_START    <= (nxt_state == ST_LEGACY_ALIGN) && (state_ff != ST_LEGACY_ALIGN);
        LINK_READY_OUT  <= (nxt_state == ST_LINK_READY) || (nxt_state == ST_LEGACY_READY)
                           && leg_ready_s;
        // Clear on reset entry wins over a same-cycle set
        if (nxt_state == ST_RESET) begin
            FALLBACK_FLAG <= 1'b0;
            SUCCESS_FLAG  <= 1'b0;
        end else begin
            if (state_ff == ST_NEGOTIATE && neg_done_s)
                SUCCESS_FLAG <= 1'b1;
            if (state_ff == ST_NEGOTIATE && neg_fail_s && SUCCESS_FLAG)
                FALLBACK_FLAG <= 1'b1;
        end
        SYNC_MON_ENABLE <= (nxt_state == ST_LINK_READY) || (nxt_state == ST_LEGACY_READY);
        STATE           <= nxt_state;
    end
end

endmodule

// File: verif/oobh_handshake_assertions.sv
`timescale 1ns/1ps
module oobh_handshake_assertions #(
    parameter HOTPLUG_CYC = 50,
    parameter IDDET_CYC   = 35
) (
    input wire        SYS_CLK,
    input wire        RST,
    input wire        POWER_ON_RESET_IN,
    input wire        UPPER_LAYER_RESET,
    input wire        SEND_INIT_BURST,
    input wire        SEND_ID_BURST,
    input wire        NEGOTIATE_START,
    input wire        LEGACY_START,
    input wire        LINK_READY_OUT,
    input wire        FALLBACK_FLAG,
    input wire        SUCCESS_FLAG,
    input wire        SYNC_MON_ENABLE,
    input wire [10:0] STATE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Dwell counters: a timer that never expires shows up as overflow
    reg [23:0] hp_ff;
    reg [23:0] id_ff;
    always @(posedge SYS_CLK) begin
        hp_ff <= (STATE == 11'h002) ? hp_ff + 24'h1 : 24'h0;
        id_ff <= (STATE == 11'h010) ? id_ff + 24'h1 : 24'h0;
    end
    //////////////////////////////////////////////////
    sequence s_left_reset;
        STATE == 11'h001 ##1 STATE != 11'h001;
    endsequence
    sequence s_enter_neg;
        STATE == 11'h008 ##1 STATE == 11'h020;
    endsequence
    property p_por;   POWER_ON_RESET_IN |-> ##[2:3] STATE == 11'h001; endproperty
    property p_upper; UPPER_LAYER_RESET |-> ##[2:3] STATE == 11'h001; endproperty
    property p_clear;
        STATE == 11'h001 |-> !LINK_READY_OUT && !SUCCESS_FLAG && !FALLBACK_FLAG;
    endproperty
    property p_init;  STATE == 11'h001 |-> SEND_INIT_BURST; endproperty
    property p_exit;  s_left_reset |-> STATE == 11'h002 || STATE == 11'h004; endproperty
    property p_id;    STATE == 11'h004 |-> SEND_ID_BURST; endproperty
    property p_neg;   s_enter_neg |-> NEGOTIATE_START ##1 !NEGOTIATE_START; endproperty
    property p_leg;   $rose(STATE[8]) |-> LEGACY_START ##1 !LEGACY_START; endproperty
    property p_hp;    hp_ff <= HOTPLUG_CYC + 3; endproperty
    property p_idd;   id_ff <= IDDET_CYC + 3; endproperty
    property p_mon;
        SYNC_MON_ENABLE == (STATE == 11'h080 || STATE == 11'h200);
    endproperty
    a_por:   assert property (p_por)   else $error("power-on reset not honoured");
    a_upper: assert property (p_upper) else $error("upper reset not honoured");
    a_clear: assert property (p_clear) else $error("ready or flags set in reset");
    a_init:  assert property (p_init)  else $error("reset bursts not requested");
    a_exit:  assert property (p_exit)  else $error("bad exit from reset");
    a_id:    assert property (p_id)    else $error("identify burst not requested");
    a_neg:   assert property (p_neg)   else $error("negotiation start pulse wrong");
    a_leg:   assert property (p_leg)   else $error("legacy start pulse wrong");
    a_hp:    assert property (p_hp)    else $error("hot-plug wait overran");
    a_idd:   assert property (p_idd)   else $error("identify wait overran");
    a_mon:   assert property (p_mon)   else $error("sync monitor enable wrong");
endmodule
bind oobh_handshake oobh_handshake_assertions #(
    .HOTPLUG_CYC(HOTPLUG_CYC),
    .IDDET_CYC  (IDDET_CYC)
) i_chk (
    .SYS_CLK, .RST, .POWER_ON_RESET_IN, .UPPER_LAYER_RESET, .SEND_INIT_BURST,
    .SEND_ID_BURST, .NEGOTIATE_START, .LEGACY_START, .LINK_READY_OUT, .FALLBACK_FLAG,
    .SUCCESS_FLAG, .SYNC_MON_ENABLE, .STATE
);

// File: verif/oobh_far_phy.sv
`timescale 1ns/1ps
module oobh_far_phy (
    input  wire       clk,
    input  wire       rst,
    input  wire       peer,
    input  wire [1:0] kick,
    input  wire       send_init,
    input  wire       send_id,
    output reg        init_sent = 1'b0,
    output reg        id_sent   = 1'b0,
    output reg        init_det  = 1'b0,
    output reg        id_det    = 1'b0,
    output reg        id_end    = 1'b0
);
    // Burst slot counter; a new kind of request starts a fresh group of six
    reg  [2:0] cnt_ff = 3'h0;
    reg  [1:0] req_ff = 2'h0;
    wire       fresh  = ({send_init, send_id} != req_ff);
    always @(posedge clk) begin
        req_ff    <= {send_init, send_id};
        cnt_ff    <= (rst || fresh || cnt_ff == 3'h5) ? 3'h0 : cnt_ff + 3'h1;
        init_sent <= send_init && !fresh && cnt_ff == 3'h5;
        id_sent   <= send_id && !fresh && cnt_ff == 3'h5;
        // Peer answers within the group; kick forces a lone detect
        init_det  <= kick[0] || (peer && send_init && !fresh && cnt_ff == 3'h3);
        id_det    <= kick[1] || (peer && send_id && !fresh && cnt_ff == 3'h2);
        id_end    <= peer && !send_id;
    end
endmodule

// File: verif/oobh_handshake_test.sv
`timescale 1ns/1ps
module oobh_handshake_test;
    localparam HP = 50;
    localparam AL = 40;
    reg         SYS_CLK, RST, POWER_ON_RESET_IN, UPPER_LAYER_RESET, NEGOTIATE_FAIL;
    reg         NEGOTIATE_DONE, LEGACY_ALIGN_SEEN, LEGACY_READY, SYNC_LOST, peer;
    reg  [1:0]  kick;
    wire        INIT_DETECT_STROBE, ID_DETECT_STROBE, ID_END_DETECT, INIT_SENT_STROBE;
    wire        ID_SENT_STROBE, SEND_INIT_BURST, SEND_ID_BURST, NEGOTIATE_START;
    wire        LEGACY_START, LINK_READY_OUT, FALLBACK_FLAG, SUCCESS_FLAG, SYNC_MON_ENABLE;
    wire [10:0] STATE;
    int         err_count = 0;
    int         checked = 0;
    int         n;
    oobh_handshake #(.HOTPLUG_CYC(24'h32), .ALIGN_CYC(24'h28), .SYNC_CYC(24'h14)) i_dut (
        .SYS_CLK, .RST, .POWER_ON_RESET_IN, .UPPER_LAYER_RESET, .INIT_DETECT_STROBE,
        .ID_DETECT_STROBE, .ID_END_DETECT, .INIT_SENT_STROBE, .ID_SENT_STROBE,
        .NEGOTIATE_FAIL, .NEGOTIATE_DONE, .LEGACY_ALIGN_SEEN, .LEGACY_READY, .SYNC_LOST,
        .SEND_INIT_BURST, .SEND_ID_BURST, .NEGOTIATE_START, .LEGACY_START, .LINK_READY_OUT,
        .FALLBACK_FLAG, .SUCCESS_FLAG, .SYNC_MON_ENABLE, .STATE
    );
    oobh_far_phy i_far (
        .clk(SYS_CLK), .rst(RST), .peer, .kick, .send_init(SEND_INIT_BURST),
        .send_id(SEND_ID_BURST), .init_sent(INIT_SENT_STROBE), .id_sent(ID_SENT_STROBE),
        .init_det(INIT_DETECT_STROBE), .id_det(ID_DETECT_STROBE), .id_end(ID_END_DETECT)
    );
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    //////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic final_report;
        $display("checked %0d, err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic ok);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: state %h", $time, STATE);
        end
    endtask
    // Bounded poll; a hang ends the run at once
    task automatic wait_st(input logic [10:0] st, input int lim);
        n = 0;
        while (STATE !== st && n < lim) begin
            cyc(1);
            n++;
        end
        chk(n < lim);
        if (n >= lim) final_report();
    endtask
    task automatic kick_det(input logic [1:0] k);
        kick = k;
        cyc(1);
        kick = 2'h0;
    endtask
    //////////////////////////////////////////////////
    initial begin
        {RST, POWER_ON_RESET_IN, peer, UPPER_LAYER_RESET, NEGOTIATE_FAIL} = 5'h1C;
        {NEGOTIATE_DONE, LEGACY_ALIGN_SEEN, LEGACY_READY, SYNC_LOST, kick} = 6'h00;
        cyc(10);
        RST = 1'b0;
        chk(STATE === 11'h001 && SEND_INIT_BURST === 1'b1 && !LINK_READY_OUT);
        cyc(40);
        chk(STATE === 11'h001 && SEND_INIT_BURST === 1'b1);
        POWER_ON_RESET_IN = 1'b0;
        wait_st(11'h004, 20);
        wait_st(11'h008, 20);
        wait_st(11'h020, 10);
        chk(NEGOTIATE_START === 1'b1);
        NEGOTIATE_DONE = 1'b1;
        cyc(1);
        NEGOTIATE_DONE = 1'b0;
        wait_st(11'h080, 10);
        chk(LINK_READY_OUT === 1'b1 && SUCCESS_FLAG === 1'b1 && SYNC_MON_ENABLE);
        SYNC_LOST = 1'b1;
        cyc(15);
        chk(STATE === 11'h080);
        wait_st(11'h001, 15);
        chk(LINK_READY_OUT === 1'b0 && SUCCESS_FLAG === 1'b0 && FALLBACK_FLAG === 1'b0);
        SYNC_LOST = 1'b0;
        wait_st(11'h020, 40);
        NEGOTIATE_FAIL = 1'b1;
        cyc(1);
        NEGOTIATE_FAIL = 1'b0;
        wait_st(11'h040, 6);
        wait_st(11'h001, HP + 10);
        chk(n > HP - 5);
        wait_st(11'h020, 40);
        NEGOTIATE_DONE = 1'b1;
        cyc(1);
        NEGOTIATE_DONE = 1'b0;
        wait_st(11'h080, 10);
        kick_det(2'h1);
        wait_st(11'h001, 6);
        // Far end gone: hot-plug retry and the lone identify burst
        peer = 1'b0;
        wait_st(11'h002, 20);
        UPPER_LAYER_RESET = 1'b1;
        cyc(1);
        UPPER_LAYER_RESET = 1'b0;
        wait_st(11'h001, 6);
        wait_st(11'h002, 20);
        wait_st(11'h001, HP + 10);
        chk(n > HP - 5);
        wait_st(11'h002, 20);
        SYNC_LOST = 1'b1;
        kick_det(2'h2);
        wait_st(11'h004, 6);
        wait_st(11'h010, 20);
        wait_st(11'h100, 45);
        chk(n > 30 && LEGACY_START === 1'b1);
        wait_st(11'h001, AL + 10);
        chk(n > AL - 5);
        SYNC_LOST = 1'b0;
        // Legacy target that mistakes the identify burst for a reset
        wait_st(11'h002, 20);
        kick_det(2'h1);
        wait_st(11'h004, 6);
        wait_st(11'h010, 20);
        kick_det(2'h1);
        wait_st(11'h100, 6);
        {LEGACY_ALIGN_SEEN, LEGACY_READY} = 2'h3;
        wait_st(11'h200, 10);
        chk(SYNC_MON_ENABLE === 1'b1 && LINK_READY_OUT === 1'b1);
        kick_det(2'h1);
        wait_st(11'h001, 6);
        // Identify burst arriving in reset is answered before any exchange
        kick_det(2'h2);
        wait_st(11'h004, 6);
        final_report();
    end
endmodule
